// ### hdl/ood_pkg.sv
`default_nettype none
package ood_pkg;
	localparam int unsigned NCH      = 8;
	localparam int unsigned CLK_HZ   = 10_000_000;
	// Glitch filter settle time, ns
	localparam int unsigned FILT_NS  = 1000;
	localparam int unsigned FILT_CYC = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned FILT_W   = 4;
	// Open-load debounce time, us
	localparam int unsigned DEB_US   = 100;
	localparam int unsigned DEB_CYC  = DEB_US * (CLK_HZ / 1_000_000);
	localparam int unsigned DEB_W    = 11;
	// Least fault hold time, ms
	localparam int unsigned HOLD_MS  = 200;
	localparam int unsigned HOLD_CYC_DFLT = HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned HOLD_W   = 21;
	// Pin positions of the dual-purpose inputs
	localparam int unsigned PIN_OL   = 0;
	localparam int unsigned PIN_CNFG = 6;
	localparam int unsigned PIN_S16  = 7;

	typedef enum logic {
		OOD_PARALLEL,
		OOD_SERIAL
	} ood_mode_t;

	// Power stage commands per channel
	typedef struct packed {
		logic [NCH-1:0] high_side_switch;
		logic [NCH-1:0] low_side_switch;
		logic [NCH-1:0] pullup_en;
	} ood_drive_t;

	// Diagnostic results per channel
	typedef struct packed {
		logic [NCH-1:0] fault_bits;
		logic [NCH-1:0] fault_led;
	} ood_diag_t;
endpackage : ood_pkg
`default_nettype wire

// ### hdl/ood_glitch.sv
`default_nettype none
module ood_glitch
	import ood_pkg::*;
#(
	parameter int unsigned N = 8
) (
	input  wire logic         core_clk, // System clock
	input  wire logic         reset,    // Sync reset, high
	input  wire logic         en,       // Filtering on
	input  wire logic [N-1:0] din,      // Raw inputs
	output logic      [N-1:0] dout      // Filtered inputs
);
	logic [N-1:0]             out_d;
	logic [N-1:0]             out_q;
	logic [N-1:0][FILT_W-1:0] cnt_d;
	logic [N-1:0][FILT_W-1:0] cnt_q;

	// With en high, a change passes only after FILT_CYC steady cycles; with en low it passes on the next edge
	always_comb begin
		out_d = out_q;
		cnt_d = cnt_q;
		for (int i = 0; i < N; i++) begin
			if (din[i] == out_q[i]) begin
				cnt_d[i] = '0;
			end else if (!en) begin
				out_d[i] = din[i];
				cnt_d[i] = '0;
			end else if (cnt_q[i] == FILT_W'(FILT_CYC - 1)) begin
				out_d[i] = din[i];
				cnt_d[i] = '0;
			end else begin
				cnt_d[i] = cnt_q[i] + FILT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			out_q <= '0;
			cnt_q <= '0;
		end else begin
			out_q <= out_d;
			cnt_q <= cnt_d;
		end
	end

	assign dout = out_q;
endmodule : ood_glitch
`default_nettype wire

// ### hdl/ood_ol_diag.sv
`default_nettype none
module ood_ol_diag
	import ood_pkg::*;
#(
	parameter int unsigned HOLD_CYC = HOLD_CYC_DFLT
) (
	input  wire logic core_clk, // System clock
	input  wire logic reset,    // Sync reset, high
	input  wire logic ol_en,    // Detection enabled
	input  wire logic hs_mode,  // Channel in high-side mode
	input  wire logic sw_on,    // Switch commanded on
	input  wire logic cmp_off,  // Output above off threshold
	input  wire logic cmp_on,   // Current below on threshold
	output logic      new_det,  // Pulse, fresh detection
	output logic      ol_flag,  // Accepted open load
	output logic      led_hold  // Fault lamp: flag set or hold running
);
	logic              raw;
	logic              sw_prev_q;
	logic              raw_prev_q;
	logic              sw_prev_d;
	logic              raw_prev_d;
	logic [DEB_W-1:0]  deb_q;
	logic [DEB_W-1:0]  deb_d;
	logic              flag_q;
	logic              flag_d;
	logic [HOLD_W-1:0] hold_q;
	logic [HOLD_W-1:0] hold_d;
	logic              det;

	// Raw verdict: off state uses voltage, on state uses current
	assign raw = ol_en && hs_mode && (sw_on ? cmp_on : cmp_off);

	// Debounce, then lamp hold restarted on every fresh detection
	always_comb begin
		sw_prev_d  = sw_on;
		raw_prev_d = raw;
		deb_d      = deb_q;
		flag_d     = flag_q;
		det        = 1'b0;
		hold_d     = hold_q;
		if (sw_on != sw_prev_q || raw != raw_prev_q) begin
			deb_d = '0;
		end else if (deb_q != DEB_W'(DEB_CYC)) begin
			deb_d = deb_q + DEB_W'(1);
		end else begin
			flag_d = raw;
			det    = raw && !flag_q;
		end
		if (det) begin
			hold_d = HOLD_W'(HOLD_CYC);
		end else if (hold_q != '0) begin
			hold_d = hold_q - HOLD_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sw_prev_q  <= 1'b0;
			raw_prev_q <= 1'b0;
			deb_q      <= '0;
			flag_q     <= 1'b0;
			hold_q     <= '0;
		end else begin
			sw_prev_q  <= sw_prev_d;
			raw_prev_q <= raw_prev_d;
			deb_q      <= deb_d;
			flag_q     <= flag_d;
			hold_q     <= hold_d;
		end
	end

	assign new_det  = det;
	assign ol_flag  = flag_q;
	assign led_hold = (hold_q != '0) || flag_q;
endmodule : ood_ol_diag
`default_nettype wire

// ### hdl/ood_ctrl.sv
`default_nettype none
module ood_ctrl
	import ood_pkg::*;
#(
	parameter int unsigned HOLD_CYC = HOLD_CYC_DFLT
) (
	input  wire logic           core_clk,              // System clock
	input  wire logic           reset,                 // Sync reset, high
	input  wire logic           serial_parallel_select, // High: serial control
	input  wire logic [NCH-1:0] channel_inputs,        // Dual-purpose pins
	input  wire logic           glitch_filter_enable,  // Filter on
	input  wire logic           drive_type_select,     // High: push-pull
	input  wire logic           output_enable,         // Low: all off
	input  wire logic           chip_select_n,         // Serial chip select
	input  wire logic [NCH-1:0] serial_out_state,      // Levels set by serial
	input  wire logic [NCH-1:0] serial_pushpull_cfg,   // Per-channel push-pull
	input  wire logic [NCH-1:0] serial_ol_enable,      // Per-channel open load
	input  wire logic           lower_pair_join,       // Pair 1-2, 3-4
	input  wire logic           upper_pair_join,       // Pair 5-6, 7-8
	input  wire logic [NCH-1:0] ol_off_cmp,            // Output above threshold
	input  wire logic [NCH-1:0] ol_on_cmp,             // Current below threshold
	input  wire logic [NCH-1:0] driver_shutdown,       // Driver shut down
	output ood_drive_t          drive,                 // Power stage commands
	output ood_diag_t           diag,                  // Fault bits and lamps
	output logic                chip_select_n_filt,    // Filtered chip select
	output logic                serial_config_mode,    // Serial config allowed
	output logic                serial_frame16,        // 16-bit frames
	output logic                fault_out,             // Global fault pin level
	output logic                fault_oe               // Global fault pull low
);
	logic [NCH-1:0]    pins_f;
	logic              cs_f;
	logic [1:0]        fixed_f;
	ood_mode_t         mode;
	logic              pp_pin;
	logic [NCH-1:0]    cmd;
	logic [NCH-1:0]    paired;
	logic [NCH-1:0]    pp_mode;
	logic [NCH-1:0]    hs_mode;
	logic [NCH-1:0]    ol_en;
	logic [NCH-1:0]    new_det;
	logic [NCH-1:0]    ol_flag;
	logic [NCH-1:0]    led_hold;
	ood_drive_t        drive_d;
	ood_drive_t        drive_q;
	ood_diag_t         diag_d;
	ood_diag_t         diag_q;
	logic              mode_cfg_d;
	logic              mode_cfg_q;
	logic              mode16_d;
	logic              mode16_q;
	logic [HOLD_W-1:0] ghold_d;
	logic [HOLD_W-1:0] ghold_q;
	logic              gfault_d;
	logic              gfault_q;

	// Parallel pins and chip select, filtered on request
	ood_glitch #(
		.N (NCH + 1)
	) u_flt_pins (
		.core_clk (core_clk),
		.reset    (reset),
		.en       (glitch_filter_enable),
		.din      ({chip_select_n, channel_inputs}),
		.dout     ({cs_f, pins_f})
	);

	// Mode and drive-type pins are always filtered
	ood_glitch #(
		.N (2)
	) u_flt_fixed (
		.core_clk (core_clk),
		.reset    (reset),
		.en       (1'b1),
		.din      ({serial_parallel_select, drive_type_select}),
		.dout     (fixed_f)
	);

	assign mode   = fixed_f[1] ? OOD_SERIAL : OOD_PARALLEL;
	assign pp_pin = fixed_f[0];

	// Channel command source and pairing
	always_comb begin
		if (mode == OOD_SERIAL) begin
			cmd = serial_out_state;
		end else begin
			cmd = pins_f;
		end
		paired = '0;
		if (lower_pair_join) begin
			cmd[1]    = cmd[0];
			cmd[3]    = cmd[2];
			paired[3:0] = '1;
		end
		if (upper_pair_join) begin
			cmd[5]    = cmd[4];
			cmd[7]    = cmd[6];
			paired[7:4] = '1;
		end
	end

	// Drive type after pairing, paired stays high-side
	assign pp_mode = (pp_pin ? '1 : serial_pushpull_cfg) & ~paired;
	assign hs_mode = ~pp_mode;

	// Open-load enable per channel
	assign ol_en = serial_ol_enable |
		{NCH{mode == OOD_SERIAL && pins_f[PIN_OL]}};

	// Per-channel diagnostics, independent even when paired
	for (genvar c = 0; c < NCH; c++) begin : g_diag
		ood_ol_diag #(
			.HOLD_CYC (HOLD_CYC)
		) u_diag (
			.core_clk (core_clk),
			.reset    (reset),
			.ol_en    (ol_en[c]),
			.hs_mode  (hs_mode[c]),
			.sw_on    (cmd[c]),
			.cmp_off  (ol_off_cmp[c]),
			.cmp_on   (ol_on_cmp[c]),
			.new_det  (new_det[c]),
			.ol_flag  (ol_flag[c]),
			.led_hold (led_hold[c])
		);
	end

	// Power stage commands
	always_comb begin
		drive_d = '0;
		if (output_enable) begin
			drive_d.high_side_switch = cmd & ~driver_shutdown;
			drive_d.low_side_switch  = pp_mode & ~cmd & ~driver_shutdown;
			drive_d.pullup_en        = ol_en & hs_mode & ~cmd;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			drive_q <= '0;
		end else begin
			drive_q <= drive_d;
		end
	end

	// Diagnostic bits and fault lamps
	always_comb begin
		diag_d.fault_bits = ol_flag | driver_shutdown;
		if (output_enable) begin
			diag_d.fault_led = led_hold | driver_shutdown;
		end else begin
			diag_d.fault_led = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			diag_q <= '0;
		end else begin
			diag_q <= diag_d;
		end
	end

	// Serial interface mode levels
	always_comb begin
		mode_cfg_d = (mode == OOD_SERIAL) && pins_f[PIN_CNFG];
		mode16_d   = (mode == OOD_SERIAL) && pins_f[PIN_S16];
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_cfg_q <= 1'b0;
			mode16_q   <= 1'b0;
		end else begin
			mode_cfg_q <= mode_cfg_d;
			mode16_q   <= mode16_d;
		end
	end

	// Global fault hold, restarted by any fresh detection
	always_comb begin
		if (|new_det) begin
			ghold_d = HOLD_W'(HOLD_CYC);
		end else if (ghold_q != '0) begin
			ghold_d = ghold_q - HOLD_W'(1);
		end else begin
			ghold_d = ghold_q;
		end
		gfault_d = (|new_det) || (ghold_q != '0) || (|ol_flag)
			|| (|driver_shutdown);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ghold_q  <= '0;
			gfault_q <= 1'b0;
		end else begin
			ghold_q  <= ghold_d;
			gfault_q <= gfault_d;
		end
	end

	// Outputs
	assign drive              = drive_q;
	assign diag               = diag_q;
	assign chip_select_n_filt = cs_f;
	assign serial_config_mode = mode_cfg_q;
	assign serial_frame16     = mode16_q;
	assign fault_out          = 1'b0;
	assign fault_oe           = gfault_q;
endmodule : ood_ctrl
`default_nettype wire

// ### testbench/ood_ctrl_monitor.sv
`default_nettype none
module ood_ctrl_monitor
	import ood_pkg::*;
#(
	parameter int unsigned HOLD_CYC = 50
) (
	input wire logic           core_clk,        // Clock
	input wire logic           reset,           // Reset
	input wire logic           output_enable,   // Enable
	input wire logic [NCH-1:0] driver_shutdown, // Shutdown
	input wire logic           lower_pair_join, // Join 1-4
	input wire logic           upper_pair_join, // Join 5-8
	input wire ood_drive_t     drive,           // Stage commands
	input wire ood_diag_t      diag,            // Faults
	input wire logic           fault_out,       // Fault pin level
	input wire logic           fault_oe         // Fault pull low
);
	logic [31:0] hold_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// Cycles since global fault went active
	always_ff @(posedge core_clk) begin
		if (reset || !fault_oe)
			hold_q <= 32'h0;
		else if (hold_q < HOLD_CYC)
			hold_q <= hold_q + 32'h1;
	end

	oe_off_a: assert property (!output_enable |=> drive.high_side_switch == 8'h0 &&
		drive.low_side_switch == 8'h0 && diag.fault_led == 8'h0) else $error("enable low left drive on");
	shut_fault_a: assert property (|driver_shutdown |=> fault_oe &&
		(drive.high_side_switch & $past(driver_shutdown)) == 8'h0) else $error("shutdown not reported");
	fault_pin_a: assert property (fault_out == 1'b0) else $error("fault pin driven high");
	no_shoot_a: assert property ((drive.high_side_switch & drive.low_side_switch) == 8'h0)
		else $error("both switches on");
	low_pair_a: assert property (lower_pair_join |=> drive.low_side_switch[3:0] == 4'h0)
		else $error("lower pair push-pull");
	up_pair_a: assert property (upper_pair_join |=> drive.low_side_switch[7:4] == 4'h0)
		else $error("upper pair push-pull");
	low_follow_a: assert property (lower_pair_join && driver_shutdown[3:0] == 4'h0 |=>
		drive.high_side_switch[1] == drive.high_side_switch[0] &&
		drive.high_side_switch[3] == drive.high_side_switch[2]) else $error("lower pair split");
	hold_min_a: assert property (hold_q != 0 && hold_q < HOLD_CYC - 2 |-> fault_oe)
		else $error("fault hold too short");
	lamp_on_a: assert property ($rose(diag.fault_bits[0]) && $past(output_enable) |->
		diag.fault_led[0]) else $error("lamp not lit");
endmodule : ood_ctrl_monitor
`default_nettype wire

// ### testbench/ood_load_model.sv
`default_nettype none
module ood_load_model
	import ood_pkg::*;
(
	input  wire ood_drive_t     drive,      // Stage commands
	input  wire logic [NCH-1:0] open_mask,  // Wires left open
	output logic      [NCH-1:0] ol_off_cmp, // Above off threshold
	output logic      [NCH-1:0] ol_on_cmp   // Below on current
);
	// Open wire pulled up by source, or no current while on
	assign ol_off_cmp = open_mask & drive.pullup_en;
	assign ol_on_cmp  = open_mask & drive.high_side_switch;
endmodule : ood_load_model
`default_nettype wire

// ### testbench/tb_ood_ctrl.sv
`default_nettype none
module tb_ood_ctrl
	import ood_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, reset = 1, sps = 0, gfe = 0, dts = 0, oe = 1, lpj = 0, upj = 0, csn = 1;
	logic [7:0] ci = 8'h0, sos = 8'h0, om = 8'h0, dsd = 8'h0, spc = 8'h0, sol = 8'h0, r, p, s, q, u, offc, onc;
	logic [31:0] seed = 32'h8A73D168;
	ood_drive_t drive;
	ood_diag_t diag;
	logic cfg, f16, fo, foe, csf;
	logic [43:0] exp_q[$];
	int errors = 0, check_count = 0, cyc = 0;

	// Hold longer than the debounce so the lamp hold shows past the flag
	ood_ctrl #(.HOLD_CYC(1500)) ood_ctrl_i (.core_clk(core_clk), .reset(reset),
		.serial_parallel_select(sps), .channel_inputs(ci), .glitch_filter_enable(gfe),
		.drive_type_select(dts), .output_enable(oe), .chip_select_n(csn), .serial_out_state(sos),
		.serial_pushpull_cfg(spc), .serial_ol_enable(sol), .lower_pair_join(lpj),
		.upper_pair_join(upj), .ol_off_cmp(offc), .ol_on_cmp(onc), .driver_shutdown(dsd),
		.drive(drive), .diag(diag), .chip_select_n_filt(csf), .serial_config_mode(cfg),
		.serial_frame16(f16), .fault_out(fo), .fault_oe(foe));
	ood_load_model ood_load_model_i (.drive(drive), .open_mask(om), .ol_off_cmp(offc), .ol_on_cmp(onc));

	// Clock and timeout
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end

	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs

	task automatic stop_test();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task automatic w(int n);
		repeat (n) @(posedge core_clk);
	endtask : w

	// Note expected outputs; m is config, frame16, fault, chip select
	task automatic put(logic [7:0] hs, ls, pu, fb, led, logic [3:0] m);
		exp_q.push_back({hs, ls, pu, fb, led, m});
		w(1);
	endtask : put

	// Compare on the falling edge, outputs settled
	always @(negedge core_clk) begin
		if (exp_q.size() != 0) begin
			logic [43:0] e, g;
			e = exp_q.pop_front();
			g = {drive, diag, cfg, f16, foe, csf};
			check_count++;
			if (g !== e) begin
				errors++;
				$display("Error t=%0t exp=%h got=%h", $time, e, g);
			end
		end
	end

	// Main sequence
	initial begin
		w(12);
		reset <= 1'b0;
		r = xs() | 8'h01;
		ci <= r;
		w(20);
		put(r, 8'h0, 8'h0, 8'h0, 8'h0, 4'h1);
		// Per-channel push-pull and open-load bits
		q = xs();
		u = xs();
		spc <= q;
		sol <= u;
		w(3);
		put(r, q & ~r, u & ~q & ~r, 8'h0, 8'h0, 4'h1);
		spc <= 8'h0;
		sol <= 8'h0;
		dts <= 1'b1;
		w(20);
		put(r, ~r, 8'h0, 8'h0, 8'h0, 4'h1);
		lpj <= 1'b1;
		upj <= 1'b1;
		w(5);
		p = {r[6], r[6], r[4], r[4], r[2], r[2], r[0], r[0]};
		put(p, 8'h0, 8'h0, 8'h0, 8'h0, 4'h1);
		oe <= 1'b0;
		w(5);
		put(8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 4'h1);
		oe <= 1'b1;
		lpj <= 1'b0;
		upj <= 1'b0;
		gfe <= 1'b1;
		w(15);
		// Short glitch on pins and chip select is dropped
		ci <= ~r;
		csn <= 1'b0;
		w(3);
		put(r, ~r, 8'h0, 8'h0, 8'h0, 4'h1);
		ci <= r;
		csn <= 1'b1;
		w(15);
		put(r, ~r, 8'h0, 8'h0, 8'h0, 4'h1);
		// A steady change passes on the tenth edge
		ci <= ~r;
		csn <= 1'b0;
		w(9);
		put(r, ~r, 8'h0, 8'h0, 8'h0, 4'h1);
		w(2);
		put(~r, r, 8'h0, 8'h0, 8'h0, 4'h0);
		gfe <= 1'b0;
		sps <= 1'b1;
		dts <= 1'b0;
		ci <= 8'hC0;
		csn <= 1'b1;
		s = xs();
		sos <= s;
		w(20);
		put(s, 8'h0, 8'h0, 8'h0, 8'h0, 4'hD);
		sos <= 8'h0;
		ci <= 8'h01;
		dts <= 1'b1;
		om <= 8'h01;
		w(1020);
		put(8'h0, 8'hFF, 8'h0, 8'h0, 8'h0, 4'h1);
		lpj <= 1'b1;
		w(990);
		put(8'h0, 8'hF0, 8'h0F, 8'h0, 8'h0, 4'h1);
		w(29);
		put(8'h0, 8'hF0, 8'h0F, 8'h01, 8'h01, 4'h3);
		// Load returns: flag clears, lamp and fault stay held
		om <= 8'h0;
		w(1020);
		put(8'h0, 8'hF0, 8'h0F, 8'h0, 8'h01, 4'h3);
		w(450);
		put(8'h0, 8'hF0, 8'h0F, 8'h0, 8'h01, 4'h3);
		w(15);
		put(8'h0, 8'hF0, 8'h0F, 8'h0, 8'h0, 4'h1);
		dsd <= 8'h80;
		w(5);
		put(8'h0, 8'h70, 8'h0F, 8'h80, 8'h80, 4'h3);
		// Mid-run reset clears every output
		reset <= 1'b1;
		w(2);
		put(8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 4'h0);
		reset <= 1'b0;
		w(3);
		stop_test();
	end
endmodule : tb_ood_ctrl

bind ood_ctrl ood_ctrl_monitor #(.HOLD_CYC(HOLD_CYC)) ood_ctrl_monitor_i (.core_clk(core_clk), .reset(reset),
	.output_enable(output_enable), .driver_shutdown(driver_shutdown), .lower_pair_join(lower_pair_join),
	.upper_pair_join(upper_pair_join), .drive(drive), .diag(diag), .fault_out(fault_out), .fault_oe(fault_oe));
`default_nettype wire
